/* File: hdl/mdf_framer_top.sv */
/*
  modem user data path: transmit input selection and receive output paths.
  assumes the modulator pulls bits with a valid/ready pair and the demodulator
  offers one bit per valid pulse, at most one bit every two clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module mdf_framer_top
  import mdf_pkg::*;
#(
  parameter int FRAME_TIMEOUT_CYCLES = MDF_FRAME_TIMEOUT_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [1:0] tx_input_select_in,
  input wire logic [31:0] tx_nominal_bit_rate_in,
  input wire logic [2:0] rx_output_path_select_in,
  input wire logic [31:0] rx_dest_ip_in,
  input wire logic [15:0] rx_dest_port_in,
  input wire logic [7:0] tx_stream_data_in,
  input wire logic tx_stream_valid_in,
  output logic tx_stream_ready_out,
  input wire logic tx_ser_clk_in,
  input wire logic tx_ser_data_in,
  output logic tx_cts_out,
  output logic tx_bitclk_out,
  output logic mod_bit_out,
  output logic mod_bit_valid_out,
  input wire logic mod_bit_ready_in,
  input wire logic demod_bit_in,
  input wire logic demod_bit_valid_in,
  output logic [7:0] rx_stream_data_out,
  output logic rx_stream_valid_out,
  input wire logic rx_stream_ready_in,
  output logic [7:0] rx_frame_data_out,
  output logic rx_frame_valid_out,
  output logic rx_frame_last_out,
  input wire logic rx_frame_ready_in,
  output logic [31:0] rx_frame_dest_ip_out,
  output logic [15:0] rx_frame_dest_port_out,
  output logic rx_ser_data_out,
  output logic rx_bitclk_out
);
  // ==========================================================================
  // pin synchronisers
  logic clk_s1, clk_s2, clk_s3, dat_s1, dat_s2;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      dat_s1 <= 1'b0;
      dat_s2 <= 1'b0;
    end else begin
      clk_s1 <= tx_ser_clk_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= tx_ser_data_in;
      dat_s2 <= dat_s1;
    end
  end

  // ==========================================================================
  // transmit path
  logic [MDF_TX_QUEUE_BITS-1:0] q, next_q;
  logic [3:0] qn, next_qn;
  logic [31:0] nco, next_nco;
  logic hold, next_hold, hold_v, next_hold_v;
  logic s_ready, next_s_ready, cts, next_cts;
  logic ser_edge, push_bit;
  logic [3:0] qa;

  function automatic logic [7:0] bit_rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      bit_rev[i] = b[7-i];
    end
  endfunction

  assign ser_edge = clk_s2 && !clk_s3;

  always_comb begin
    next_q = q;
    next_qn = qn;
    next_hold = hold;
    next_hold_v = hold_v;
    next_nco = nco;
    push_bit = 1'b0;
    qa = '0;
    if (hold_v && mod_bit_ready_in) begin
      next_hold_v = 1'b0;
    end
    if (!next_hold_v && (qn != 4'h0)) begin
      next_hold = q[0];
      next_hold_v = 1'b1;
      next_q = {1'b0, q[MDF_TX_QUEUE_BITS-1:1]};
      next_qn = qn - 4'h1;
    end
    if (tx_input_select_in == MDF_TX_SEL_PLAIN) begin
      next_nco = nco + tx_nominal_bit_rate_in;
    end else begin
      next_nco = '0;
    end
    unique case (tx_input_select_in)
      MDF_TX_SEL_STREAM: begin
        if (s_ready && tx_stream_valid_in) begin
          next_q = bit_rev(tx_stream_data_in);
          next_qn = 4'h8;
        end
      end
      MDF_TX_SEL_CLOCKED: push_bit = ser_edge;
      // source changes on the falling edge, so the rising edge sees settled data
      MDF_TX_SEL_PLAIN: push_bit = next_nco[31] && !nco[31];
      default: push_bit = 1'b0;
    endcase
    // a full queue drops the bit; in clocked mode the flag below keeps that from happening
    if (push_bit && (next_qn < 4'(MDF_TX_QUEUE_BITS))) begin
      qa = next_qn;
      next_q[qa[2:0]] = dat_s2;
      next_qn = next_qn + 4'h1;
    end
    // byte accepted only into an empty queue: the source stalls otherwise
    next_s_ready = (tx_input_select_in == MDF_TX_SEL_STREAM) && (next_qn == 4'h0) &&
                   !(s_ready && tx_stream_valid_in);
    // low early: bits already in the synchroniser still find room
    next_cts = (tx_input_select_in == MDF_TX_SEL_CLOCKED) &&
               (next_qn < MDF_CTS_LOW_LEVEL);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      qn <= '0;
      nco <= '0;
      hold <= 1'b0;
      hold_v <= 1'b0;
      s_ready <= 1'b0;
      cts <= 1'b0;
    end else begin
      q <= next_q;
      qn <= next_qn;
      nco <= next_nco;
      hold <= next_hold;
      hold_v <= next_hold_v;
      s_ready <= next_s_ready;
      cts <= next_cts;
    end
  end

  assign tx_stream_ready_out = s_ready;
  assign tx_cts_out = cts;
  assign tx_bitclk_out = nco[31];
  assign mod_bit_out = hold;
  assign mod_bit_valid_out = hold_v;

  // ==========================================================================
  // receive path
  mdf_frame_if fif ();
  logic [7:0] rb, next_rb, sd, next_sd;
  logic [2:0] rbn, next_rbn;
  logic sv, next_sv, fv, next_fv, rsd, next_rsd, rck, next_rck, byte_done;
  logic [31:0] dip;
  logic [15:0] dport;

  assign byte_done = demod_bit_valid_in && (rbn == 3'h7);

  always_comb begin
    next_rb = rb;
    next_rbn = rbn;
    next_sd = sd;
    next_sv = sv;
    next_fv = 1'b0;
    next_rsd = rsd;
    next_rck = 1'b1;
    if (demod_bit_valid_in) begin
      next_rb = {rb[6:0], demod_bit_in};
      next_rbn = rbn + 3'h1;
    end
    if (sv && rx_stream_ready_in) begin
      next_sv = 1'b0;
    end
    unique case (rx_output_path_select_in)
      MDF_RX_SEL_STREAM: begin
        // no stall on the demodulator side: an unread byte is overwritten
        if (byte_done) begin
          next_sd = next_rb;
          next_sv = 1'b1;
        end
      end
      MDF_RX_SEL_DATAGRAM: next_fv = byte_done;
      MDF_RX_SEL_SERIAL: begin
        // data changes with the clock low, stable across the next rise
        if (demod_bit_valid_in) begin
          next_rsd = demod_bit_in;
          next_rck = 1'b0;
        end
      end
      default: next_fv = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rb <= '0;
      rbn <= '0;
      sd <= '0;
      sv <= 1'b0;
      fv <= 1'b0;
      rsd <= 1'b0;
      rck <= 1'b1;
      dip <= '0;
      dport <= '0;
    end else begin
      rb <= next_rb;
      rbn <= next_rbn;
      sd <= next_sd;
      sv <= next_sv;
      fv <= next_fv;
      rsd <= next_rsd;
      rck <= next_rck;
      dip <= rx_dest_ip_in;
      dport <= rx_dest_port_in;
    end
  end

  assign fif.byte_data = sd_frame(rb);
  assign fif.byte_valid = fv;
  assign fif.frame_ready = rx_frame_ready_in;

  function automatic logic [7:0] sd_frame(input logic [7:0] b);
    sd_frame = b;
  endfunction

  mdf_udp_framer #(
    .TIMEOUT_CYCLES(FRAME_TIMEOUT_CYCLES)
  ) u_framer (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .fi(fif.framer)
  );

  assign rx_stream_data_out = sd;
  assign rx_stream_valid_out = sv;
  assign rx_frame_data_out = fif.frame_data;
  assign rx_frame_valid_out = fif.frame_valid;
  assign rx_frame_last_out = fif.frame_last;
  assign rx_frame_dest_ip_out = dip;
  assign rx_frame_dest_port_out = dport;
  assign rx_ser_data_out = rsd;
  assign rx_bitclk_out = rck;
endmodule
`default_nettype wire

/* File: hdl/mdf_udp_framer.sv */
/*
  datagram framer: gathers receive bytes, sends header plus payload.
  assumes the consumer of frame bytes may stall; bytes offered while a frame
  is being sent are refused (byte_ready low) and the feeder drops them.
*/
`timescale 1ns/1ps
`default_nettype none
module mdf_udp_framer
  import mdf_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = MDF_FRAME_TIMEOUT_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  mdf_frame_if.framer fi
);
  // ==========================================================================
  // storage and state
  logic [7:0] mem [MDF_FRAME_MAX_BYTES];
  mdf_fr_state_t state, next_state;
  logic [MDF_FRAME_CNT_W-1:0] cnt, next_cnt;
  logic [MDF_FRAME_IDX_W-1:0] idx, next_idx;
  logic [31:0] timer, next_timer;
  logic [15:0] seq, next_seq;
  logic [7:0] odata, next_odata;
  logic ovalid, next_ovalid;
  logic olast, next_olast;
  logic wr;

  function automatic logic [7:0] hdr_byte(input logic [3:0] i, input logic [15:0] sz,
                                          input logic [15:0] sq);
    case (i)
      MDF_HDR_SIZE_HI: hdr_byte = sz[15:8];
      MDF_HDR_SIZE_LO: hdr_byte = sz[7:0];
      MDF_HDR_SEQ_HI: hdr_byte = sq[15:8];
      MDF_HDR_SEQ_LO: hdr_byte = sq[7:0];
      default: hdr_byte = 8'h00;
    endcase
  endfunction

  assign fi.byte_ready = (state == MDF_FR_FILL);
  assign fi.frame_data = odata;
  assign fi.frame_valid = ovalid;
  assign fi.frame_last = olast;
  assign wr = fi.byte_valid && (state == MDF_FR_FILL);

  // ==========================================================================
  // next state
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_idx = idx;
    next_timer = timer;
    next_seq = seq;
    next_odata = odata;
    next_ovalid = ovalid;
    next_olast = olast;
    unique case (state)
      MDF_FR_FILL: begin
        if (wr) begin
          next_cnt = cnt + 11'h001;
        end
        // the half-second window opens with the first byte of the frame
        if (cnt != '0) begin
          next_timer = timer + 32'h0000_0001;
        end
        if ((next_cnt == MDF_FRAME_CNT_W'(MDF_FRAME_MAX_BYTES)) ||
            ((cnt != '0) && (timer >= 32'(TIMEOUT_CYCLES - 1)))) begin
          next_state = MDF_FR_SEND;
          next_idx = '0;
          next_timer = '0;
        end
      end
      MDF_FR_SEND: begin
        if (ovalid && olast && fi.frame_ready) begin
          next_ovalid = 1'b0;
          next_olast = 1'b0;
          next_state = MDF_FR_FILL;
          next_cnt = '0;
          next_seq = seq + 16'h0001;
        end else if (!ovalid || fi.frame_ready) begin
          // size, counter, twelve zero bytes, then payload
          if (idx < MDF_FRAME_IDX_W'(MDF_FRAME_HDR_BYTES)) begin
            next_odata = hdr_byte(idx[3:0], 16'(cnt), seq);
          end else begin
            next_odata = mem[10'(idx - MDF_FRAME_IDX_W'(MDF_FRAME_HDR_BYTES))];
          end
          next_ovalid = 1'b1;
          next_olast = (idx == MDF_FRAME_IDX_W'(cnt) + MDF_FRAME_IDX_W'(MDF_FRAME_HDR_BYTES - 1));
          next_idx = idx + 11'h001;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (wr) begin
      mem[10'(cnt)] <= fi.byte_data;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state <= MDF_FR_FILL;
      cnt <= '0;
      idx <= '0;
      timer <= '0;
      seq <= '0;
      odata <= '0;
      ovalid <= 1'b0;
      olast <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      timer <= next_timer;
      seq <= next_seq;
      odata <= next_odata;
      ovalid <= next_ovalid;
      olast <= next_olast;
    end
  end
endmodule
`default_nettype wire

/* File: include/mdf_frame_if.sv */
/*
  byte feed into the datagram framer and frame byte stream out of it.
  assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface mdf_frame_if;
  logic [7:0] byte_data;
  logic byte_valid;
  logic byte_ready;
  logic [7:0] frame_data;
  logic frame_valid;
  logic frame_last;
  logic frame_ready;
  modport framer(input byte_data, byte_valid, frame_ready,
                 output byte_ready, frame_data, frame_valid, frame_last);
  modport feeder(output byte_data, byte_valid, frame_ready,
                 input byte_ready, frame_data, frame_valid, frame_last);
endinterface
`default_nettype wire

/* File: include/mdf_pkg.sv */
/*
  constants, types and timing figures shared by the modem data port framer.
  assumes a 250 MHz system clock; everything here is elaboration-time only.
*/
package mdf_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] MDF_TX_NOMINAL_BIT_RATE_OFFSET = 8'h12;
  localparam int MDF_TX_NOMINAL_BIT_RATE_WIDTH = 32;
  // ==========================================================================
  // network ports served by the transmit and receive stream paths
  localparam logic [15:0] MDF_TX_STREAM_PORT = 16'h0400;
  localparam logic [15:0] MDF_RX_STREAM_PORT = 16'h0401;
  // ==========================================================================
  // transmit input select codes
  localparam logic [1:0] MDF_TX_SEL_STREAM = 2'h0;
  localparam logic [1:0] MDF_TX_SEL_CLOCKED = 2'h1;
  localparam logic [1:0] MDF_TX_SEL_PLAIN = 2'h2;
  // ==========================================================================
  // receive output path codes
  localparam logic [2:0] MDF_RX_SEL_STREAM = 3'h1;
  localparam logic [2:0] MDF_RX_SEL_DATAGRAM = 3'h2;
  localparam logic [2:0] MDF_RX_SEL_SERIAL = 3'h3;
  // ==========================================================================
  // datagram frame layout
  localparam int MDF_FRAME_MAX_BYTES = 1024;
  localparam int MDF_FRAME_HDR_BYTES = 16;
  localparam int MDF_FRAME_CNT_W = 11;
  localparam int MDF_FRAME_IDX_W = 11;
  localparam logic [3:0] MDF_HDR_SIZE_HI = 4'h0;
  localparam logic [3:0] MDF_HDR_SIZE_LO = 4'h1;
  localparam logic [3:0] MDF_HDR_SEQ_HI = 4'h2;
  localparam logic [3:0] MDF_HDR_SEQ_LO = 4'h3;
  // ==========================================================================
  // timing
  localparam int MDF_CLK_FREQ_KHZ = 250000;
  localparam int MDF_FRAME_TIMEOUT_MS = 500;
  localparam int MDF_FRAME_TIMEOUT_CYCLES = MDF_FRAME_TIMEOUT_MS * MDF_CLK_FREQ_KHZ;
  localparam int MDF_TX_QUEUE_BITS = 8;
  localparam logic [3:0] MDF_CTS_LOW_LEVEL = 4'h4;
  // ==========================================================================
  // types
  typedef enum logic {MDF_FR_FILL, MDF_FR_SEND} mdf_fr_state_t;
endpackage

/* File: verification/mdf_framer_props.sv */
/*
  port assertions for the modem data port framer.
  assumes it is bound onto mdf_framer_top, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module mdf_framer_props
  import mdf_pkg::*;
#(
  parameter int FRAME_TIMEOUT_CYCLES = 200
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [1:0] tx_input_select_in,
  input wire logic [7:0] tx_stream_data_in,
  input wire logic tx_stream_valid_in,
  input wire logic tx_stream_ready_out,
  input wire logic tx_cts_out,
  input wire logic tx_bitclk_out,
  input wire logic mod_bit_out,
  input wire logic mod_bit_valid_out,
  input wire logic mod_bit_ready_in,
  input wire logic demod_bit_in,
  input wire logic demod_bit_valid_in,
  input wire logic [2:0] rx_output_path_select_in,
  input wire logic rx_ser_data_out,
  input wire logic rx_bitclk_out,
  input wire logic [7:0] rx_frame_data_out,
  input wire logic rx_frame_valid_out,
  input wire logic rx_frame_last_out,
  input wire logic rx_frame_ready_in,
  input wire logic [31:0] rx_dest_ip_in,
  input wire logic [31:0] rx_frame_dest_ip_out
);
  // ======
  // checks
  logic first_bit;
  assign first_bit = tx_stream_data_in[7];
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  cts_mode_a: assert property (
    $stable(tx_input_select_in) && tx_input_select_in != MDF_TX_SEL_CLOCKED |-> !tx_cts_out)
    else $error("clear to send high outside clocked mode");
  bitclk_mode_a: assert property (
    $stable(tx_input_select_in) && tx_input_select_in != MDF_TX_SEL_PLAIN |-> !tx_bitclk_out)
    else $error("bit clock running outside plain mode");
  ready_drop_a: assert property (
    tx_stream_ready_out && tx_stream_valid_in |=> !tx_stream_ready_out ##1 mod_bit_valid_out)
    else $error("stream byte taken without stall");
  first_bit_a: assert property (
    tx_stream_ready_out && tx_stream_valid_in && (!mod_bit_valid_out || mod_bit_ready_in) |->
      ##2 mod_bit_valid_out && mod_bit_out == $past(first_bit, 2))
    else $error("stream byte not sent msb first");
  bit_hold_a: assert property (
    mod_bit_valid_out && !mod_bit_ready_in |=> mod_bit_valid_out && $stable(mod_bit_out))
    else $error("modulator bit lost while stalled");
  ser_out_a: assert property (
    demod_bit_valid_in && rx_output_path_select_in == MDF_RX_SEL_SERIAL |=>
      !rx_bitclk_out && rx_ser_data_out == $past(demod_bit_in) ##1 rx_bitclk_out)
    else $error("serial bit not set before clock rise");
  frame_hold_a: assert property (
    rx_frame_valid_out && !rx_frame_ready_in |=>
      rx_frame_valid_out && $stable(rx_frame_data_out) && $stable(rx_frame_last_out))
    else $error("frame byte changed while stalled");
  dest_copy_a: assert property (
    1'b1 |=> rx_frame_dest_ip_out == $past(rx_dest_ip_in))
    else $error("destination address not forwarded");
endmodule
bind mdf_framer_top mdf_framer_props #(.FRAME_TIMEOUT_CYCLES(FRAME_TIMEOUT_CYCLES)) u_props (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .tx_input_select_in(tx_input_select_in),
  .tx_stream_data_in(tx_stream_data_in), .tx_stream_valid_in(tx_stream_valid_in),
  .tx_stream_ready_out(tx_stream_ready_out), .tx_cts_out(tx_cts_out),
  .tx_bitclk_out(tx_bitclk_out), .mod_bit_out(mod_bit_out), .mod_bit_valid_out(mod_bit_valid_out),
  .mod_bit_ready_in(mod_bit_ready_in), .demod_bit_in(demod_bit_in),
  .demod_bit_valid_in(demod_bit_valid_in), .rx_output_path_select_in(rx_output_path_select_in),
  .rx_ser_data_out(rx_ser_data_out), .rx_bitclk_out(rx_bitclk_out),
  .rx_frame_data_out(rx_frame_data_out), .rx_frame_valid_out(rx_frame_valid_out),
  .rx_frame_last_out(rx_frame_last_out), .rx_frame_ready_in(rx_frame_ready_in),
  .rx_dest_ip_in(rx_dest_ip_in), .rx_frame_dest_ip_out(rx_frame_dest_ip_out));
`default_nettype wire

/* File: verification/mdf_ser_src.sv */
/*
  external serial data source: one byte per go, msb first.
  assumes its own 160 ns link clock in clocked mode and the bit clock input in plain mode, idle between bytes.
*/
`timescale 1ns/1ps
`default_nettype none
module mdf_ser_src
  import mdf_pkg::*;
(
  input wire logic [1:0] mode_in,
  input wire logic [7:0] byte_in,
  input wire logic go_in,
  input wire logic cts_in,
  input wire logic bitclk_in,
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic done_out
);
  initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    done_out = 1'b0;
  end
  always @(posedge go_in) begin
    done_out = 1'b0;
    if (mode_in == MDF_TX_SEL_PLAIN) begin
      @(negedge bitclk_in);
      for (int i = 7; i >= 0; i--) begin
        ser_data_out = byte_in[i];
        @(negedge bitclk_in);
      end
    end else begin
      for (int i = 7; i >= 0; i--) begin
        while (!cts_in) #80;
        ser_data_out = byte_in[i];
        #80 ser_clk_out = 1'b1;
        #80 ser_clk_out = 1'b0;
      end
    end
    // released line: inverse of last bit so a stale sample shows
    ser_data_out = !ser_data_out;
    done_out = 1'b1;
  end
endmodule
`default_nettype wire

/* File: verification/tb_mdf_framer_top.sv */
/*
  self-checking bench: bench plays modulator, demodulator and frame sink.
  assumes the serial source model on the transmit pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_mdf_framer_top;
  import mdf_pkg::*;
  localparam int TMO = 30000;
  logic clk = 0, rst = 1, tvld = 0, mrdy = 1, dbit = 0, dvld = 0, frdy = 0, go = 0, hit = 0;
  logic srdy = 0;
  logic [1:0] tsel = MDF_TX_SEL_STREAM;
  logic [2:0] rsel = 3'h0;
  logic [7:0] tdat = 8'h00, sbyte = 8'h00, sdata, fdata;
  logic [15:0] sh = 16'h0000, msk = 16'h0000, exp16 = 16'h0000, fport;
  logic [31:0] fip;
  logic sclk, sdat, sdone, tready, cts, bclk, mbit, mvld, svld, fvld, flast, rbclk, rser;
  logic [7:0] fq[$];
  int nfr = 0, error_cnt = 0, comparisons = 0, n, k;
  always #2 clk = ~clk;
  mdf_framer_top #(.FRAME_TIMEOUT_CYCLES(TMO)) dut (
    .clk_sys_in(clk), .rst_in(rst), .tx_input_select_in(tsel),
    .tx_nominal_bit_rate_in(32'h1000_0000), .rx_output_path_select_in(rsel),
    .rx_dest_ip_in(32'hC0A8_0A14), .rx_dest_port_in(16'h1F90), .tx_stream_data_in(tdat),
    .tx_stream_valid_in(tvld), .tx_stream_ready_out(tready), .tx_ser_clk_in(sclk),
    .tx_ser_data_in(sdat), .tx_cts_out(cts), .tx_bitclk_out(bclk), .mod_bit_out(mbit),
    .mod_bit_valid_out(mvld), .mod_bit_ready_in(mrdy), .demod_bit_in(dbit),
    .demod_bit_valid_in(dvld), .rx_stream_data_out(sdata), .rx_stream_valid_out(svld),
    .rx_stream_ready_in(srdy), .rx_frame_data_out(fdata), .rx_frame_valid_out(fvld),
    .rx_frame_last_out(flast), .rx_frame_ready_in(frdy), .rx_frame_dest_ip_out(fip),
    .rx_frame_dest_port_out(fport), .rx_ser_data_out(rser), .rx_bitclk_out(rbclk));
  mdf_ser_src src (.mode_in(tsel), .byte_in(sbyte), .go_in(go), .cts_in(cts),
    .bitclk_in(bclk), .ser_clk_out(sclk), .ser_data_out(sdat), .done_out(sdone));
  // ======
  // modulator bit window and frame sink, sink stalls every other cycle
  always @(posedge clk) if (mvld && mrdy) begin
    sh <= {sh[14:0], mbit};
    if (({sh[14:0], mbit} & msk) == exp16) hit <= 1'b1;
  end
  always @(posedge clk) if (fvld && frdy) begin
    fq.push_back(fdata);
    if (flast) nfr <= nfr + 1;
  end
  always @(posedge clk) frdy <= (rsel == MDF_RX_SEL_DATAGRAM) ? ~frdy : 1'b0;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      $display("unexpected %s: expected %h seen %h", what, expv, seen);
      error_cnt++;
    end
  endtask
  task automatic close_out;
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wait_eq(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  // valid held until the edge where ready is seen high
  task automatic tx_byte(input logic [7:0] b);
    tdat = b;
    tvld = 1'b1;
    n = 0;
    do begin @(negedge clk); n++; end while (tready !== 1'b1 && n < 200);
    check("stream ready", tready, 1);
    tick(1);
  endtask
  task automatic demod_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      dbit = b[i];
      dvld = 1'b1;
      tick(1);
      dvld = 1'b0;
      tick(1);
    end
  endtask
  task automatic chk_frame(input int plen, input logic [15:0] cnt);
    k = nfr;
    n = 0;
    while (nfr == k && n < TMO + 3000) begin tick(1); n++; end
    check("frame length", 32'(fq.size()), 32'(16 + plen));
    check("size field", {fq[0], fq[1]}, 32'(plen));
    check("frame counter", {fq[2], fq[3]}, cnt);
    for (int i = 4; i < 16 + plen; i++) check("frame byte", fq[i], (i < 16) ? 0 : (i - 16) & 255);
    fq.delete();
  endtask
  initial begin #400000; error_cnt++; close_out; end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    tick(2);
    check("dest ip", fip, 32'hC0A8_0A14);
    check("dest port", fport, 16'h1F90);
    msk = 16'hFFFF; exp16 = 16'hA53C;
    tx_byte(8'hA5);
    tx_byte(8'h3C);
    tvld = 1'b0;
    tick(40);
    check("stream bits", hit, 1);
    msk = 16'h00FF; exp16 = 16'h0096; hit = 0; mrdy = 0; sbyte = 8'h96;
    tsel = MDF_TX_SEL_CLOCKED;
    tick(4);
    check("cts idle", cts, 1);
    go = 1'b1;
    wait_eq(cts, 1'b0, 4000);
    check("cts full", cts, 0);
    tick(200);
    mrdy = 1'b1;
    wait_eq(sdone, 1'b1, 4000);
    tick(20);
    check("clocked bits", hit, 1);
    go = 1'b0; tsel = MDF_TX_SEL_PLAIN;
    wait_eq(bclk, 1'b1, 100);
    wait_eq(bclk, 1'b0, 100);
    k = n;
    wait_eq(bclk, 1'b1, 100);
    check("bit clock period", k + n, 16);
    exp16 = 16'h00C3; hit = 0; sbyte = 8'hC3; go = 1'b1;
    tick(1);
    wait_eq(sdone, 1'b1, 2000);
    tick(20);
    check("plain bits", hit, 1);
    tsel = 2'h3; rsel = MDF_RX_SEL_SERIAL;
    demod_byte(8'h5B);
    check("serial bit", rser, 1);
    check("serial clock idle", rbclk, 1);
    rsel = MDF_RX_SEL_STREAM;
    demod_byte(8'h96);
    wait_eq(svld, 1'b1, 20);
    check("stream valid", svld, 1);
    check("stream byte", sdata, 8'h96);
    rsel = MDF_RX_SEL_DATAGRAM;
    for (int i = 0; i < 1024; i++) demod_byte(8'(i));
    chk_frame(1024, 16'h0000);
    demod_byte(8'h00);
    chk_frame(1, 16'h0001);
    close_out;
  end
endmodule
`default_nettype wire
